/* File: logic/asp_pkg.sv */
package asp_pkg;
    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CLAMP = 8'h04;
    localparam logic [7:0] ADDR_MSG = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0c;
    // Writable bits of each register; all other bits read as zero.
    localparam logic [31:0] CTRL_MASK = 32'h0000_3fff;
    localparam logic [31:0] CLAMP_MASK = 32'h0fff_0fff;
    localparam logic [31:0] MSG_MASK = 32'h0000_0fff;
    // Values after reset.
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] CLAMP_RST = 32'h0080_0080;
    localparam logic [31:0] MSG_RST = 32'h0000_0000;
    // Field positions.
    localparam int CL_LO_LSB = 0;
    localparam int CL_HI_LSB = 16;
    localparam int MSG_ID_LSB = 0;
    localparam int MSG_MAG_LSB = 4;
    localparam int ST_RC_LSB = 8;
    // Bus answers.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Clock and SENT timing.
    localparam int unsigned CLK_NS = 20;
    localparam logic [13:0] QUARTER_NS = 14'h00fa;
    localparam logic [6:0] SYNC_TICKS = 7'h38;
    localparam logic [6:0] LOW_TICKS = 7'h05;
    localparam logic [6:0] NIB_BASE_TICKS = 7'h0c;
    localparam logic [8:0] FRAME_TICKS = 9'h110;
    localparam logic [2:0] LAST_NIB = 3'h7;
    localparam logic [3:0] CRC_SEED = 4'h5;
    localparam logic [3:0] CRC_POLY = 4'hd;
    // PWM frame and failure bands.
    localparam logic [12:0] PWM_FRAME = 13'h1000;
    localparam logic [11:0] FAIL_LOW = 12'h040;
    localparam logic [11:0] FAIL_HIGH = 12'hfc0;
    localparam logic [11:0] SLOW_STEP = 12'h008;
    localparam logic [11:0] SENT_FAIL_LOW = 12'h000;
    localparam logic [11:0] SENT_FAIL_HIGH = 12'hfff;

    typedef enum logic [1:0] {
        OS_PUSH = 2'h0,
        OS_PDOWN = 2'h1,
        OS_PUP = 2'h2,
        OS_SENT = 2'h3
    } asp_os_t;

    // Control register layout, bits 13:0.
    typedef struct packed {
        logic failure_band_select;
        logic pause_pulse_enable;
        logic rolling_counter_disable;
        logic serial_message_enable;
        logic [4:0] tick_period_select;
        logic pwm_step_rate;
        logic pwm_frame_rate;
        logic pwm_invert;
        asp_os_t output_stage_select;
    } asp_cfg_t;

    // Diagnostic inputs from the sensor core.
    typedef struct packed {
        logic watchdog;
        logic adc_check;
        logic signature;
        logic offset_incomplete;
        logic cordic_overflow;
        logic field_range;
    } asp_fault_t;

    // Tick period in nanoseconds, built from quarter microseconds.
    function automatic logic [13:0] asp_tick_ns(input logic [4:0] code);
        logic [5:0] q;
        q = 6'h0c;
        unique case (code)
            5'h00: q = 6'h0c; 5'h01: q = 6'h10; 5'h02: q = 6'h12; 5'h03: q = 6'h14;
            5'h04: q = 6'h16; 5'h05: q = 6'h17; 5'h06: q = 6'h1a; 5'h07: q = 6'h1b;
            5'h08: q = 6'h1e; 5'h09: q = 6'h20; 5'h0a: q = 6'h22; 5'h0b: q = 6'h24;
            5'h0c: q = 6'h26; 5'h0d: q = 6'h28; 5'h0e: q = 6'h29; 5'h0f: q = 6'h2a;
            5'h10: q = 6'h2b; 5'h11: q = 6'h2c; 5'h12: q = 6'h2d; 5'h13: q = 6'h2e;
            5'h14: q = 6'h2f; 5'h15: q = 6'h30; 5'h16: q = 6'h31; 5'h17: q = 6'h32;
            5'h18: q = 6'h09; 5'h19: q = 6'h0a; 5'h1a: q = 6'h0b; 5'h1b: q = 6'h0c;
            5'h1c: q = 6'h0d; 5'h1d: q = 6'h0e; 5'h1e: q = 6'h0e; 5'h1f: q = 6'h0e;
        endcase
        return 14'(q * QUARTER_NS);
    endfunction : asp_tick_ns

    // One nibble of the SENT CRC-4, most significant bit first.
    function automatic logic [3:0] asp_crc_nib(input logic [3:0] crc, input logic [3:0] nib);
        logic [3:0] c;
        logic fb;
        c = crc;
        for (int i = 3; i >= 0; i--) begin
            fb = c[3] ^ nib[i];
            c = {c[2:0], 1'b0};
            if (fb) begin
                c = c ^ CRC_POLY;
            end
        end
        return c;
    endfunction : asp_crc_nib
endpackage : asp_pkg

/* File: logic/asp_sent_pwm.sv */
// Implementation choices: the register offsets and the AXI4-Lite slave port.
module asp_sent_pwm #(
    parameter int unsigned PWM_DIV_FAST = 12, // System clocks per PWM clock, fast frame rate.
    parameter int unsigned PWM_DIV_SLOW = 24 // System clocks per PWM clock, slow frame rate.
) (
    input wire logic aclk, // System clock, 50 MHz.
    input wire logic aresetn, // Synchronous reset, active low.
    input wire logic [7:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [7:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    input wire logic [11:0] angle, // Measured angle from the transfer function.
    input asp_pkg::asp_fault_t faults, // Diagnostic fault levels.
    output logic out_o, // Output pin drive value.
    output logic out_oe // Output pin enable, high while driving.
);
    import asp_pkg::*;

    typedef enum logic [2:0] {
        S_SYNC = 3'b001,
        S_NIB = 3'b010,
        S_PAUSE = 3'b100
    } asp_state_t;
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] be, input logic [31:0] mask);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r & mask;
    endfunction : wmerge

    // Register bus and configuration state.
    logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
    logic [7:0] waddr_r, waddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [31:0] ctrl_r, ctrl_nxt, clamp_r, clamp_nxt, msg_r, msg_nxt;
    asp_cfg_t cfg;
    logic [11:0] cl_lo, cl_hi;

    // Diagnostic state.
    logic [2:0] fatal_r, fatal_nxt;
    logic recov, diag, hiz;

    // SENT state.
    asp_state_t st_r, st_nxt;
    logic [13:0] acc_r, acc_nxt, tick_ns;
    logic [14:0] acc_sum;
    logic tick;
    logic [6:0] seg_r, seg_nxt, seg_len;
    logic [8:0] used_r, used_nxt;
    logic [2:0] nib_r, nib_nxt;
    logic [3:0] nibs_r [8];
    logic [3:0] nibs_nxt [8];
    logic [7:0] rc_r, rc_nxt;
    logic [3:0] ssm_idx_r, ssm_idx_nxt;
    logic [15:0] ssm_r, ssm_nxt;
    logic sent_lvl;

    // PWM state.
    logic [5:0] div_r, div_nxt;
    logic [11:0] pos_r, pos_nxt, duty_r, duty_nxt;
    logic pwm_lvl;

    // Pin state.
    logic out_r, out_nxt, oe_r, oe_nxt;

    assign cfg = asp_cfg_t'(ctrl_r[$bits(asp_cfg_t)-1:0]);
    assign cl_lo = clamp_r[CL_LO_LSB +: 12];
    assign cl_hi = clamp_r[CL_HI_LSB +: 12];
    assign s_axi_awready = ~aw_got_r;
    assign s_axi_wready = ~w_got_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign out_o = out_r;
    assign out_oe = oe_r;

    // Address and data are caught separately in either order; the write lands once both
    // are held and the previous response has gone, so at most one write is in flight.
    always_comb begin
        aw_got_nxt = aw_got_r;
        w_got_nxt = w_got_r;
        waddr_nxt = waddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        ctrl_nxt = ctrl_r;
        clamp_nxt = clamp_r;
        msg_nxt = msg_r;
        if (s_axi_awvalid && !aw_got_r) begin
            aw_got_nxt = 1'b1;
            waddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_got_r) begin
            w_got_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (aw_got_r && w_got_r && !bvalid_r) begin
            aw_got_nxt = 1'b0;
            w_got_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = RESP_OKAY;
            unique case (waddr_r)
                ADDR_CTRL: ctrl_nxt = wmerge(ctrl_r, wdata_r, wstrb_r, CTRL_MASK);
                ADDR_CLAMP: clamp_nxt = wmerge(clamp_r, wdata_r, wstrb_r, CLAMP_MASK);
                ADDR_MSG: msg_nxt = wmerge(msg_r, wdata_r, wstrb_r, MSG_MASK);
                ADDR_STAT: bresp_nxt = RESP_OKAY;
                default: bresp_nxt = RESP_SLVERR;
            endcase
        end
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = RESP_OKAY;
            unique case (s_axi_araddr)
                ADDR_CTRL: rdata_nxt = ctrl_r;
                ADDR_CLAMP: rdata_nxt = clamp_r;
                ADDR_MSG: rdata_nxt = msg_r;
                ADDR_STAT: rdata_nxt = {16'h0000, rc_r, 1'b0, hiz, faults[2:0], fatal_r};
                default: begin
                    rdata_nxt = 32'h0000_0000;
                    rresp_nxt = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            waddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h0000_0000;
            ctrl_r <= CTRL_RST;
            clamp_r <= CLAMP_RST;
            msg_r <= MSG_RST;
        end else begin
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            waddr_r <= waddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
            ctrl_r <= ctrl_nxt;
            clamp_r <= clamp_nxt;
            msg_r <= msg_nxt;
        end
    end

    // Non-recoverable faults stick until reset; the others are followed live.
    always_comb begin
        fatal_nxt = fatal_r | {faults.watchdog, faults.adc_check, faults.signature};
        recov = faults.offset_incomplete | faults.cordic_overflow | faults.field_range;
        diag = fatal_r[1] | fatal_r[0] | recov;
        hiz = fatal_r[2];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fatal_r <= 3'h0;
        end else begin
            fatal_r <= fatal_nxt;
        end
    end

    // Tick enable from a nanosecond accumulator, so quarter-microsecond periods that are
    // not whole clock multiples still average out exactly.
    always_comb begin
        tick_ns = asp_tick_ns(cfg.tick_period_select);
        acc_sum = {1'b0, acc_r} + 15'(CLK_NS);
        tick = acc_sum >= {1'b0, tick_ns};
        acc_nxt = tick ? 14'(acc_sum - {1'b0, tick_ns}) : acc_sum[13:0];
    end

    // SENT segment sequencer: sync, eight nibbles, optional pause.
    always_comb begin
        logic [11:0] a;
        logic [15:0] word;
        logic [3:0] crc;
        logic build;
        a = 12'h000;
        word = 16'h0000;
        crc = CRC_SEED;
        build = 1'b0;
        st_nxt = st_r;
        seg_nxt = seg_r;
        used_nxt = used_r;
        nib_nxt = nib_r;
        nibs_nxt = nibs_r;
        rc_nxt = rc_r;
        ssm_idx_nxt = ssm_idx_r;
        ssm_nxt = ssm_r;
        seg_len = SYNC_TICKS;
        unique case (st_r)
            S_SYNC: seg_len = SYNC_TICKS;
            S_NIB: seg_len = NIB_BASE_TICKS + {3'h0, nibs_r[nib_r]};
            S_PAUSE: seg_len = 7'(FRAME_TICKS - used_r);
        endcase
        sent_lvl = seg_r >= LOW_TICKS;
        if (tick) begin
            if (seg_r == seg_len - 7'h01) begin
                seg_nxt = 7'h00;
                used_nxt = used_r + {2'h0, seg_len};
                unique case (st_r)
                    S_SYNC: begin
                        st_nxt = S_NIB;
                        nib_nxt = 3'h0;
                    end
                    S_NIB: begin
                        nib_nxt = nib_r + 3'h1;
                        if (nib_r == LAST_NIB) begin
                            if (cfg.pause_pulse_enable) begin
                                st_nxt = S_PAUSE;
                            end else begin
                                build = 1'b1;
                            end
                        end
                    end
                    S_PAUSE: build = 1'b1;
                endcase
            end else begin
                seg_nxt = seg_r + 7'h01;
            end
        end
        // Next telegram starts right after the previous one; nothing waits on the receiver.
        if (build) begin
            st_nxt = S_SYNC;
            used_nxt = 9'h000;
            a = diag ? (cfg.failure_band_select ? SENT_FAIL_HIGH : SENT_FAIL_LOW) : angle;
            word = ssm_r;
            if (ssm_idx_r == 4'h0) begin
                crc = asp_crc_nib(CRC_SEED, msg_r[MSG_ID_LSB +: 4]);
                crc = asp_crc_nib(crc, msg_r[MSG_MAG_LSB + 4 +: 4]);
                crc = asp_crc_nib(crc, msg_r[MSG_MAG_LSB +: 4]);
                crc = asp_crc_nib(crc, 4'h0);
                word = {msg_r[MSG_ID_LSB +: 4], msg_r[MSG_MAG_LSB +: 8], crc};
                ssm_nxt = word;
            end
            if (cfg.serial_message_enable) begin
                nibs_nxt[0] = {ssm_idx_r == 4'h0, word[4'hf - ssm_idx_r], 1'b0, diag | hiz};
                ssm_idx_nxt = ssm_idx_r + 4'h1;
            end else begin
                nibs_nxt[0] = {3'h0, diag | hiz};
                ssm_idx_nxt = 4'h0;
            end
            nibs_nxt[1] = a[11:8];
            nibs_nxt[2] = a[7:4];
            nibs_nxt[3] = a[3:0];
            nibs_nxt[4] = cfg.rolling_counter_disable ? 4'h0 : rc_r[7:4];
            nibs_nxt[5] = cfg.rolling_counter_disable ? 4'h0 : rc_r[3:0];
            nibs_nxt[6] = ~a[11:8];
            rc_nxt = cfg.rolling_counter_disable ? 8'h00 : rc_r + 8'h01;
            crc = CRC_SEED;
            for (int i = 1; i < 7; i++) begin
                crc = asp_crc_nib(crc, nibs_nxt[i]);
            end
            nibs_nxt[7] = asp_crc_nib(crc, 4'h0);
        end
    end

    // Outside SENT mode the sequencer parks one tick before a fresh telegram, so switching
    // to SENT always opens with a full sync pulse carrying current data.
    always_ff @(posedge aclk) begin
        if (!aresetn || cfg.output_stage_select != OS_SENT) begin
            st_r <= S_PAUSE;
            acc_r <= 14'h0000;
            seg_r <= 7'h00;
            used_r <= FRAME_TICKS - 9'h001;
            nib_r <= 3'h0;
            nibs_r <= '{default: 4'h0};
            rc_r <= 8'h00;
            ssm_idx_r <= 4'h0;
            ssm_r <= 16'h0000;
        end else begin
            st_r <= st_nxt;
            acc_r <= acc_nxt;
            seg_r <= seg_nxt;
            used_r <= used_nxt;
            nib_r <= nib_nxt;
            nibs_r <= nibs_nxt;
            rc_r <= rc_nxt;
            ssm_idx_r <= ssm_idx_nxt;
            ssm_r <= ssm_nxt;
        end
    end

    // PWM: 4096 PWM clocks per frame, duty loaded at frame start so a frame never tears.
    always_comb begin
        logic [11:0] tgt;
        logic [12:0] hi_lim;
        tgt = angle;
        hi_lim = PWM_FRAME - {1'b0, cl_hi};
        div_nxt = div_r + 6'h01;
        pos_nxt = pos_r;
        duty_nxt = duty_r;
        if (div_r == 6'(cfg.pwm_frame_rate ? PWM_DIV_SLOW - 1 : PWM_DIV_FAST - 1)) begin
            div_nxt = 6'h00;
            pos_nxt = pos_r + 12'h001;
        end
        if ({1'b0, tgt} > hi_lim) begin
            tgt = hi_lim[11:0];
        end
        if (tgt < cl_lo) begin
            tgt = cl_lo;
        end
        if (diag) begin
            tgt = cfg.failure_band_select ? FAIL_HIGH : FAIL_LOW;
        end
        if (div_nxt == 6'h00 && pos_nxt == 12'h000) begin
            duty_nxt = tgt;
            if (cfg.pwm_step_rate && !diag) begin
                if (tgt > duty_r + SLOW_STEP) begin
                    duty_nxt = duty_r + SLOW_STEP;
                end else if (tgt + SLOW_STEP < duty_r) begin
                    duty_nxt = duty_r - SLOW_STEP;
                end
            end
        end
        pwm_lvl = (pos_r < duty_r) ^ cfg.pwm_invert;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_r <= 6'h00;
            pos_r <= 12'h000;
            duty_r <= FAIL_LOW;
        end else begin
            div_r <= div_nxt;
            pos_r <= pos_nxt;
            duty_r <= duty_nxt;
        end
    end

    // Driver style: open-collector styles drive only one level and release for the other.
    always_comb begin
        logic lvl;
        lvl = (cfg.output_stage_select == OS_SENT) ? sent_lvl : pwm_lvl;
        out_nxt = lvl;
        oe_nxt = 1'b1;
        unique case (cfg.output_stage_select)
            OS_PUSH, OS_SENT: oe_nxt = 1'b1;
            OS_PDOWN: begin
                out_nxt = 1'b1;
                oe_nxt = lvl;
            end
            OS_PUP: begin
                out_nxt = 1'b0;
                oe_nxt = ~lvl;
            end
        endcase
        if (hiz) begin
            oe_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_r <= 1'b0;
            oe_r <= 1'b0;
        end else begin
            out_r <= out_nxt;
            oe_r <= oe_nxt;
        end
    end
endmodule : asp_sent_pwm

/* File: verification/asp_props.sv */
module asp_props
    import asp_pkg::*;
(
    input wire logic aclk, // Clock.
    input wire logic aresetn, // Reset, active low.
    input wire logic s_axi_awvalid, // Bus.
    input wire logic s_axi_awready, // Bus.
    input wire logic s_axi_wvalid, // Bus.
    input wire logic s_axi_wready, // Bus.
    input wire logic [1:0] s_axi_bresp, // Bus.
    input wire logic s_axi_bvalid, // Bus.
    input wire logic s_axi_bready, // Bus.
    input wire logic [7:0] s_axi_araddr, // Bus.
    input wire logic s_axi_arvalid, // Bus.
    input wire logic s_axi_arready, // Bus.
    input wire logic [31:0] s_axi_rdata, // Bus.
    input wire logic [1:0] s_axi_rresp, // Bus.
    input wire logic s_axi_rvalid, // Bus.
    input wire logic s_axi_rready, // Bus.
    input asp_pkg::asp_fault_t faults, // Fault levels.
    input wire logic out_oe // Pin enable.
);
    logic [2:0] wd_cnt_r;
    logic [2:0] wd_cnt_nxt;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Counts edges after a watchdog trip; it saturates so the check stays armed till reset.
    always_comb begin
        wd_cnt_nxt = wd_cnt_r;
        if ((faults.watchdog || wd_cnt_r != 3'h0) && wd_cnt_r != 3'h4) begin
            wd_cnt_nxt = wd_cnt_r + 3'h1;
        end
    end
    always_ff @(posedge aclk) begin
        wd_cnt_r <= aresetn ? wd_cnt_nxt : 3'h0;
    end
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
    a_addr_held: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("address taken twice");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    a_bad_addr: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h0c |=>
        s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad read answered");
    a_wdog_release: assert property (wd_cnt_r == 3'h4 |-> !out_oe)
        else $error("pin driven after watchdog");
endmodule : asp_props

bind asp_sent_pwm asp_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .faults, .out_oe);

/* File: verification/asp_rx_model.sv */
module asp_rx_model #(
    parameter logic PULL = 1'b1 // Line level while the pin is released.
) (
    input wire logic aclk, // Sampling clock.
    input wire logic out_o, // Pin drive value.
    input wire logic out_oe, // Pin enable.
    output logic line // Resolved line level.
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    int hi = 0;
    logic prev = 1'b1;
    int per_q[$];
    int hi_q[$];
    // The load resistor sets the line whenever the pin lets go.
    assign line = out_oe ? out_o : PULL;
    // Times falling edges mid-cycle, so the sample never races the pin flop.
    always @(negedge aclk) begin
        cnt++;
        hi += int'(line);
        if (prev && !line) begin
            per_q.push_back(cnt);
            hi_q.push_back(hi);
            cnt = 0;
            hi = 0;
        end
        prev = line;
    end
endmodule : asp_rx_model

/* File: verification/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import asp_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [11:0] angle = 12'h0;
    asp_fault_t faults = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic out_o, out_oe, line;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int error_cnt = 0;
    int checks = 0;
    // Short PWM dividers keep each frame at 4096 or 8192 clocks.
    asp_sent_pwm #(.PWM_DIV_FAST(1), .PWM_DIV_SLOW(2)) u_asp_sent_pwm (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .angle, .faults, .out_o, .out_oe);
    asp_rx_model u_rx (.aclk, .out_o, .out_oe, .line);
    always #10 aclk = ~aclk;
    task automatic print_verdict;
        if (error_cnt == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end while (!s_axi_bvalid && n < 64);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(RESP_OKAY), 32'(s_axi_bresp));
        if (n == 64) begin
            error_cnt++;
            print_verdict();
        end
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end while (!s_axi_rvalid && n < 64);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 64) begin
            error_cnt++;
            print_verdict();
        end
    endtask : rd
    // Waits for k falling edges at the receiver; a dead pin ends the run.
    task automatic wait_per(input int k);
        int n;
        n = 0;
        while (u_rx.per_q.size() < k && n < 40000) begin
            @(posedge aclk);
            n++;
        end
        if (n == 40000) begin
            error_cnt++;
            print_verdict();
        end
    endtask : wait_per
    // High clocks per PWM frame; clamps are at their reset level of 128.
    function automatic int exp_hi(input logic [31:0] c, input logic f, input logic [11:0] an);
        int du;
        du = an < 12'h080 ? 128 : (an > 12'hf80 ? 3968 : int'(an));
        if (f) du = c[13] ? int'(FAIL_HIGH) : int'(FAIL_LOW);
        return (c[2] ? 4096 - du : du) * (c[3] ? 2 : 1);
    endfunction : exp_hi
    function automatic logic [31:0] tk(input int p);
        return 32'((p * 20 + 1125) / 2250);
    endfunction : tk
    // Six data nibbles plus the zero augment nibble, seed 5, most significant bit first.
    function automatic logic [3:0] sent_crc(input logic [27:0] v);
        logic [3:0] c;
        c = 4'h5;
        for (int i = 27; i >= 0; i--) c = {c[2:0], 1'b0} ^ ((c[3] ^ v[i]) ? 4'hd : 4'h0);
        return c;
    endfunction : sent_crc
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [11:0] a;
        logic [3:0] nb[8];
        logic [31:0] pc[3] = '{32'h0, 32'h2004, 32'h8};
        int s;
        int sum;
        void'($urandom(32'he8f0));
        a = 12'($urandom_range(3968, 128));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ADDR_CTRL, d, r);
        chk("ctrl", CTRL_RST, d);
        rd(ADDR_CLAMP, d, r);
        chk("clamp", CLAMP_RST, d);
        rd(8'h10, d, r);
        chk("bad_rsp", 32'(RESP_SLVERR), 32'(r));
        wr(ADDR_MSG, 32'hffff_ffff);
        rd(ADDR_MSG, d, r);
        chk("msg", MSG_MASK, d);
        // Plain frame, inverted frame in the upper band, then slow frame clamped low.
        for (int i = 0; i < 3; i++) begin
            faults <= asp_fault_t'(6'(i == 1));
            angle <= (i == 2) ? 12'h005 : a;
            wr(ADDR_CTRL, pc[i]);
            u_rx.per_q.delete();
            u_rx.hi_q.delete();
            wait_per(3);
            chk("pwm_hi", 32'(exp_hi(pc[i], i == 1, i == 2 ? 12'h005 : a)), 32'(u_rx.hi_q[2]));
            chk("pwm_per", pc[i][3] ? 32'd8192 : 32'd4096, 32'(u_rx.per_q[2]));
        end
        // The pause can never last 56 ticks here, so the sync is found without doubt.
        angle <= a;
        faults <= '0;
        wr(ADDR_CTRL, 32'h1b03);
        u_rx.per_q.delete();
        wait_per(12);
        nb = '{4'h0, a[11:8], a[7:4], a[3:0], 4'h0, 4'h0, ~a[11:8], 4'h0};
        nb[7] = sent_crc({a, 8'h00, ~a[11:8], 4'h0});
        s = 10;
        while (s < u_rx.per_q.size() - 1 && tk(u_rx.per_q[s]) != 56) s++;
        chk("sync", 32'd56, tk(u_rx.per_q[s]));
        sum = u_rx.per_q[s - 1];
        for (int k = 0; k < 8; k++) begin
            chk("nibble", 32'(12 + nb[k]), tk(u_rx.per_q[s - 9 + k]));
            sum += u_rx.per_q[s - 9 + k];
        end
        chk("frame", 32'd216, tk(sum));
        faults <= asp_fault_t'(6'h20);
        repeat (5) @(posedge aclk);
        chk("pin_oe", 32'h0, 32'(out_oe));
        faults <= '0;
        rd(ADDR_STAT, d, r);
        chk("stat", 32'h44, d & 32'h7f);
        print_verdict();
    end
endmodule : tb_top
